/* inc/crf_defs.svh */
// constants for the converter ready flag and serial readout block
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// on-chip register selection codes carried in the low bits of the comms byte
`define CRF_SEL_COMMS 3'h0
`define CRF_SEL_STATUS 3'h1
`define CRF_SEL_MODE 3'h2
`define CRF_SEL_CTRL 3'h3
`define CRF_SEL_MAIN_DATA 3'h4
`define CRF_SEL_AUX_DATA 3'h5
`define CRF_SEL_CALIB 3'h6

// comms byte layout
`define CRF_COMMS_LEN 5'h08
`define CRF_COMMS_RD_BIT 6
`define CRF_COMMS_SEL_MSB 2

// status bit positions
`define CRF_STAT_MAIN_BIT 0
`define CRF_STAT_AUX_BIT 1
`define CRF_STAT_HOLD_BIT 2

// wishbone byte offsets
`define CRF_WB_CTRL 4'h0
`define CRF_WB_STATUS 4'h4
`define CRF_WB_COMMS 4'h8

// control register fields and reset value
`define CRF_CTRL_MAIN_EN_BIT 0
`define CRF_CTRL_AUX_EN_BIT 1
`define CRF_CTRL_RESET 2'h3

`endif

/* inc/crf_pkg.sv */
// types shared by the converter ready flag block
`default_nettype none
package crf_pkg;

    // synchronised serial pin levels
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } crf_pins_t;

    // serial frame phase
    typedef enum logic [0:0] {
        CRF_ST_COMMS = 1'b0,
        CRF_ST_DATA = 1'b1
    } crf_state_t;

endpackage : crf_pkg
`default_nettype wire

/* logic/crf_regmem.sv */
// small register memory for the serially written setup registers
`timescale 1ns/1ps
`default_nettype none

module crf_regmem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_ff [DEPTH]; // storage, no reset needed for data
    logic [WIDTH-1:0] rdata_ff; // registered read word

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("crf_regmem: depth or width out of range");
        end
    endgenerate

    // write port and registered read port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_ff[waddr_i] <= wdata_i;
        end
        rdata_ff <= mem_ff[raddr_i];
    end

    assign rdata_o = rdata_ff;
endmodule : crf_regmem

`default_nettype wire

/* logic/crf_top.sv */
// ready flag, serial shift registers and wishbone control of the converter
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
// Overview of operation
// - ready low while any valid unread result
// - ready high after full word read, unless another enabled result stays unread
// - ready high before next update, unread
// - ready low after calibration finishes
// - ready pin is NOR of main and aux status bits
// - disabled converter does not affect ready
// - after calibration hold low until mode write
// - output shifter loaded from selected register
// - input shifter written into selected setup register (mode, ctrl or calib only)
module crf_top #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // converter core side
    input wire logic [DATA_W-1:0] main_result_i,
    input wire logic main_update_i,
    input wire logic [DATA_W-1:0] aux_result_i,
    input wire logic aux_update_i,
    input wire logic pre_update_i,
    input wire logic cal_done_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic rdy_n_o,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    generate
        if (DATA_W < 8 || DATA_W > 24) begin : g_bad
            $error("crf_top: DATA_W must lie between 8 and 24");
        end
    endgenerate

    // three-stage pin synchronisers and filtered levels
    crf_pkg::crf_pins_t s1_ff, s2_ff, s3_ff; // stage 1 is read only by stage 2
    crf_pkg::crf_pins_t pin_ff, nxt_pin; // levels accepted when stages 2 and 3 agree

    always_comb begin
        nxt_pin = pin_ff;
        if (s2_ff.sclk == s3_ff.sclk) nxt_pin.sclk = s3_ff.sclk;
        if (s2_ff.cs_n == s3_ff.cs_n) nxt_pin.cs_n = s3_ff.cs_n;
        if (s2_ff.din == s3_ff.din) nxt_pin.din = s3_ff.din;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
            s2_ff <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
            s3_ff <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
            pin_ff <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
        end else begin
            s1_ff <= '{sclk: sclk_i, cs_n: cs_n_i, din: din_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // edges of the filtered serial clock, only inside a frame
    logic sclk_rise, sclk_fall;
    assign sclk_rise = nxt_pin.sclk & ~pin_ff.sclk & ~pin_ff.cs_n;
    assign sclk_fall = ~nxt_pin.sclk & pin_ff.sclk & ~pin_ff.cs_n;

    // serial framing state
    crf_pkg::crf_state_t st_ff, nxt_st; // comms byte or data word phase
    logic [4:0] cnt_ff, nxt_cnt; // bits taken in this phase
    logic [DATA_W-1:0] in_sr_ff, nxt_in_sr; // input shift register
    logic [DATA_W-1:0] out_sr_ff, nxt_out_sr; // output shift register
    logic rd_ff, nxt_rd; // current access is a read
    logic [2:0] sel_ff, nxt_sel; // selected on-chip register
    logic load_ff, nxt_load; // load output shifter next cycle
    logic word_done; // full data word moved this cycle
    logic [DATA_W-1:0] mem_rdata; // setup register read word
    logic mem_we;

    // status and result state
    logic main_rdy_ff, nxt_main_rdy; // main converter ready bit
    logic aux_rdy_ff, nxt_aux_rdy; // aux converter ready bit
    logic hold_ff, nxt_hold; // calibration result held until mode write
    logic [DATA_W-1:0] main_data_ff, nxt_main_data;
    logic [DATA_W-1:0] aux_data_ff, nxt_aux_data;
    logic rdy_n_ff, nxt_rdy_n;
    logic [1:0] ctrl_ff, nxt_ctrl; // converter enables from software
    logic main_stat, aux_stat; // status bits as seen by software
    logic [DATA_W-1:0] status_word;

    // a disabled converter never shows ready
    assign main_stat = main_rdy_ff & ctrl_ff[`CRF_CTRL_MAIN_EN_BIT];
    assign aux_stat = aux_rdy_ff & ctrl_ff[`CRF_CTRL_AUX_EN_BIT];
    always_comb begin
        status_word = '0;
        status_word[`CRF_STAT_MAIN_BIT] = main_stat;
        status_word[`CRF_STAT_AUX_BIT] = aux_stat;
        status_word[`CRF_STAT_HOLD_BIT] = hold_ff;
    end

    // serial shifting and frame sequencing
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_in_sr = in_sr_ff;
        nxt_out_sr = out_sr_ff;
        nxt_rd = rd_ff;
        nxt_sel = sel_ff;
        nxt_load = 1'b0;
        word_done = 1'b0;
        mem_we = 1'b0;
        if (pin_ff.cs_n) begin
            // deselect aborts any partial transfer, next byte is comms
            nxt_st = crf_pkg::CRF_ST_COMMS;
            nxt_cnt = '0;
        end else if (load_ff) begin
            // output shifter takes the selected register
            if (sel_ff == `CRF_SEL_STATUS) begin
                nxt_out_sr = status_word;
            end else if (sel_ff == `CRF_SEL_MAIN_DATA) begin
                nxt_out_sr = main_data_ff;
            end else if (sel_ff == `CRF_SEL_AUX_DATA) begin
                nxt_out_sr = aux_data_ff;
            end else if (sel_ff == `CRF_SEL_COMMS) begin
                nxt_out_sr = '0;
            end else begin
                nxt_out_sr = mem_rdata;
            end
        end else if (sclk_fall && st_ff == crf_pkg::CRF_ST_DATA && cnt_ff != 5'h00) begin
            // first bit is presented at load, later bits on falling edges
            nxt_out_sr = {out_sr_ff[DATA_W-2:0], 1'b0};
        end else if (sclk_rise) begin
            nxt_in_sr = {in_sr_ff[DATA_W-2:0], nxt_pin.din};
            nxt_cnt = cnt_ff + 5'h01;
            case (st_ff)
                crf_pkg::CRF_ST_COMMS: begin
                    if (cnt_ff + 5'h01 == `CRF_COMMS_LEN) begin
                        nxt_rd = nxt_in_sr[`CRF_COMMS_RD_BIT];
                        nxt_sel = nxt_in_sr[`CRF_COMMS_SEL_MSB:0];
                        nxt_cnt = '0;
                        nxt_st = crf_pkg::CRF_ST_DATA;
                        nxt_load = nxt_in_sr[`CRF_COMMS_RD_BIT];
                    end
                end
                crf_pkg::CRF_ST_DATA: begin
                    if (cnt_ff + 5'h01 == 5'(DATA_W)) begin
                        word_done = 1'b1;
                        nxt_cnt = '0;
                        nxt_st = crf_pkg::CRF_ST_COMMS;
                        // written word goes to the selected setup register
                        mem_we = ~rd_ff && (sel_ff == `CRF_SEL_MODE ||
                                 sel_ff == `CRF_SEL_CTRL || sel_ff == `CRF_SEL_CALIB);
                    end
                end
                default: nxt_st = crf_pkg::CRF_ST_COMMS;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= crf_pkg::CRF_ST_COMMS;
            cnt_ff <= '0;
            in_sr_ff <= '0;
            out_sr_ff <= '0;
            rd_ff <= 1'b0;
            sel_ff <= `CRF_SEL_COMMS;
            load_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            in_sr_ff <= nxt_in_sr;
            out_sr_ff <= nxt_out_sr;
            rd_ff <= nxt_rd;
            sel_ff <= nxt_sel;
            load_ff <= nxt_load;
        end
    end

    // setup registers: read address follows the select being latched, so the word is ready at load
    crf_regmem #(.WIDTH(DATA_W), .DEPTH(8)) u_regmem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(sel_ff),
        .wdata_i(nxt_in_sr),
        .raddr_i(nxt_sel),
        .rdata_o(mem_rdata)
    );

    // ready bits: a new result or calibration end wins over any clear
    always_comb begin
        nxt_main_rdy = main_rdy_ff;
        nxt_aux_rdy = aux_rdy_ff;
        nxt_hold = hold_ff;
        nxt_main_data = main_data_ff;
        nxt_aux_data = aux_data_ff;
        if (word_done && rd_ff && sel_ff == `CRF_SEL_MAIN_DATA && !hold_ff) begin
            nxt_main_rdy = 1'b0;
        end
        if (word_done && rd_ff && sel_ff == `CRF_SEL_AUX_DATA) begin
            nxt_aux_rdy = 1'b0;
        end
        if (pre_update_i && !hold_ff) begin
            // stale result withdrawn so a read does not straddle the update
            nxt_main_rdy = 1'b0;
            nxt_aux_rdy = 1'b0;
        end
        if (mem_we && sel_ff == `CRF_SEL_MODE) begin
            nxt_hold = 1'b0;
            nxt_main_rdy = 1'b0;
        end
        if (main_update_i) begin
            nxt_main_rdy = 1'b1;
            nxt_main_data = main_result_i;
        end
        if (aux_update_i) begin
            nxt_aux_rdy = 1'b1;
            nxt_aux_data = aux_result_i;
        end
        if (cal_done_i) begin
            nxt_hold = 1'b1;
            nxt_main_rdy = 1'b1;
        end
        // pin is low when any enabled status bit shows ready
        nxt_rdy_n = ~(nxt_main_rdy & ctrl_ff[`CRF_CTRL_MAIN_EN_BIT] |
                      nxt_aux_rdy & ctrl_ff[`CRF_CTRL_AUX_EN_BIT]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_rdy_ff <= 1'b0;
            aux_rdy_ff <= 1'b0;
            hold_ff <= 1'b0;
            main_data_ff <= '0;
            aux_data_ff <= '0;
            rdy_n_ff <= 1'b1;
        end else begin
            main_rdy_ff <= nxt_main_rdy;
            aux_rdy_ff <= nxt_aux_rdy;
            hold_ff <= nxt_hold;
            main_data_ff <= nxt_main_data;
            aux_data_ff <= nxt_aux_data;
            rdy_n_ff <= nxt_rdy_n;
        end
    end

    assign rdy_n_o = rdy_n_ff;
    assign dout_o = out_sr_ff[DATA_W-1];

    // wishbone slave: ack one cycle after the strobe, unmapped reads zero
    logic ack_ff, nxt_ack;
    logic [31:0] wb_dat_ff, nxt_wb_dat;
    logic wb_req;
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;

    always_comb begin
        nxt_ack = wb_req;
        nxt_wb_dat = wb_dat_ff;
        nxt_ctrl = ctrl_ff;
        if (wb_req) begin
            nxt_wb_dat = '0;
            if (wb_adr_i == `CRF_WB_CTRL) begin
                nxt_wb_dat[1:0] = ctrl_ff;
                if (wb_we_i && wb_sel_i[0]) nxt_ctrl = wb_dat_i[1:0];
            end else if (wb_adr_i == `CRF_WB_STATUS) begin
                nxt_wb_dat[DATA_W-1:0] = status_word;
            end else if (wb_adr_i == `CRF_WB_COMMS) begin
                nxt_wb_dat[3:0] = {rd_ff, sel_ff};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            wb_dat_ff <= '0;
            ctrl_ff <= `CRF_CTRL_RESET;
        end else begin
            ack_ff <= nxt_ack;
            wb_dat_ff <= nxt_wb_dat;
            ctrl_ff <= nxt_ctrl;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = wb_dat_ff;
endmodule : crf_top
`default_nettype wire

/* testbench/crf_top_props.sv */
// concurrent checks on the ports of the converter ready flag block
`timescale 1ns/1ps
`default_nettype none
module crf_top_props #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic main_update_i,
    input wire logic aux_update_i,
    input wire logic cal_done_i,
    input wire logic dout_o,
    input wire logic rdy_n_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req; // bus request not yet answered
    logic [1:0] en_ff; // mirror of the enables: a disabled path must not pull
    logic [1:0] nxt_en;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // enable mirror follows control writes at the taking edge
    always_comb begin
        nxt_en = en_ff;
        if (req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]) begin
            nxt_en = wb_dat_i[1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        en_ff <= rst_i ? 2'h3 : nxt_en;
    end
    ack_next_a: assert property (req |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'hc
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    status_nor_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4
        |-> rdy_n_o == !(|(wb_dat_o[1:0] & en_ff))) else $error("ready pin not nor of bits");
    main_low_a: assert property (main_update_i && en_ff[0]
        |-> ##[1:3] !rdy_n_o) else $error("main result did not pull ready low");
    aux_low_a: assert property (aux_update_i && en_ff[1]
        |-> ##[1:3] !rdy_n_o) else $error("aux result did not pull ready low");
    cal_low_a: assert property (cal_done_i && en_ff[0]
        |-> ##[1:3] !rdy_n_o) else $error("calibration end did not pull ready low");
    reset_idle_a: assert property ($fell(rst_i) |-> rdy_n_o && !wb_ack_o && !dout_o
        && wb_dat_o == 32'h0000_0000) else $error("outputs not idle after reset");
endmodule : crf_top_props
bind crf_top crf_top_props #(.DATA_W(DATA_W)) props_u (.clk_i(clk_i), .rst_i(rst_i),
    .main_update_i(main_update_i), .aux_update_i(aux_update_i), .cal_done_i(cal_done_i),
    .dout_o(dout_o), .rdy_n_o(rdy_n_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* testbench/crf_host_model.sv */
// serial host model: clock idles high, data driven on falling, sampled on rising
`timescale 1ns/1ps
`default_nettype none
module crf_host_model (
    input wire logic dout_i,
    input wire logic rdy_n_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // one frame: comms byte then one 16 bit word, msb first
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        rd = 16'h0000;
        if (cmd[6] && cmd[2:1] == 2'b10) begin
            wait (rdy_n_i === 1'b0);
        end
        cs_n_o = 1'b0;
        #100;
        for (int i = 23; i >= 0; i--) begin
            sclk_o = 1'b0;
            din_o = sh[i];
            #62.5;
            sclk_o = 1'b1;
            if (i < 16) begin
                rd[i] = dout_i;
            end
            #62.5;
        end
        #100;
        cs_n_o = 1'b1;
        din_o = ~din_o; // released line has no pull: show the inverse, not the last bit
    endtask : frame
endmodule : crf_host_model
`default_nettype wire

/* testbench/crf_top_tb.sv */
// self-checking bench for the converter ready flag block
`timescale 1ns/1ps
`default_nettype none
module crf_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] main_r = 16'h0000;
    logic [15:0] aux_r = 16'h0000;
    logic [3:0] evt = 4'h0; // {cal_done, pre_update, aux_update, main_update}
    logic sclk, cs_n, din, dout, rdy_n, ack;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic [15:0] r; // word read over the serial link
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    crf_top #(.DATA_W(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .main_result_i(main_r),
        .main_update_i(evt[0]), .aux_result_i(aux_r), .aux_update_i(evt[1]),
        .pre_update_i(evt[2]), .cal_done_i(evt[3]), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .rdy_n_o(rdy_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack));
    crf_host_model host_u (.dout_i(dout), .rdy_n_i(rdy_n), .sclk_o(sclk), .cs_n_o(cs_n),
        .din_o(din));
    always #4 clk_i = ~clk_i;
    // a hang is cut short well past the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            $display("FAIL %0t timeout", $time);
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic ev(input logic [3:0] m);
        evt <= m;
        @(posedge clk_i);
        evt <= 4'h0;
        repeat (4) @(posedge clk_i);
    endtask : ev
    task automatic ser(input logic [7:0] c, input logic [15:0] w);
        host_u.frame(c, w, r);
        repeat (4) @(posedge clk_i); // realign to the clock after the link frame
    endtask : ser
    task automatic t_regs();
        chk(16'(rdy_n), 16'h0001);
        wb(1'b0, 4'h0, 32'h0000_0000);
        chk(q[15:0], 16'h0003);
        wb(1'b1, 4'h4, 32'h0000_0007);
        wb(1'b1, 4'hc, 32'h0000_ffff);
        wb(1'b0, 4'hc, 32'h0000_0000);
        chk(q[15:0], 16'h0000);
        wb(1'b0, 4'h4, 32'h0000_0000);
        chk(q[15:0], 16'h0000);
    endtask : t_regs
    task automatic t_read(input logic [3:0] m, input logic [7:0] c, input logic [15:0] v,
        input logic e);
        main_r <= m[0] ? v : main_r;
        aux_r <= m[1] ? v : aux_r;
        ev(m);
        chk(16'(rdy_n), 16'h0000);
        ser(c, 16'h0000);
        chk(r, v);
        chk(16'(rdy_n), 16'(e));
    endtask : t_read
    task automatic t_misc();
        ev(4'h1);
        wb(1'b0, 4'h4, 32'h0000_0000);
        chk(q[15:0], 16'h0001);
        ev(4'h4);
        chk(16'(rdy_n), 16'h0001);
        ev(4'h8);
        chk(16'(rdy_n), 16'h0000);
        ser(8'h41, 16'h0000);
        chk(r, 16'h0005);
        ser(8'h40, 16'h0000);
        chk(r, 16'h0000);
        ev(4'h4);
        chk(16'(rdy_n), 16'h0000);
        ser(8'h02, 16'h1234);
        chk(16'(rdy_n), 16'h0001);
        ser(8'h42, 16'h0000);
        chk(r, 16'h1234);
        wb(1'b1, 4'h0, 32'h0000_0001);
        ev(4'h2);
        chk(16'(rdy_n), 16'h0001);
        ev(4'h1);
        chk(16'(rdy_n), 16'h0000);
        ev(4'h4);
        wb(1'b1, 4'h0, 32'h0000_0003);
        ser(8'h03, 16'h0077);
        ser(8'h06, 16'hbeef);
        ser(8'h43, 16'h0000);
        chk(r, 16'h0077);
        ser(8'h46, 16'h0000);
        chk(r, 16'hbeef);
        wb(1'b0, 4'h8, 32'h0000_0000);
        chk(q[15:0], 16'h000e);
    endtask : t_misc
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        t_regs();
        t_read(4'h1, 8'h44, 16'ha5c3, 1'b1);
        t_read(4'h3, 8'h44, 16'h5a3c, 1'b0);
        t_read(4'h0, 8'h45, 16'h5a3c, 1'b1);
        t_misc();
        finish_test();
    end
endmodule : crf_top_tb
`default_nettype wire
